// ==== verilog/socket_id_and_status_regs.sv ====
// Identification and interface status registers for the two card sockets.
`timescale 1ns/1ps
`include "socket_id_status_consts.svh"
module socket_id_and_status_regs #(
  parameter int         NUM_SOCKETS  = 2,
  parameter logic [1:0] IFACE_KIND   = 2'h3,  // Value is arbitrary.
  parameter logic [3:0] REV_DEFAULT  = 4'h1   // Value is arbitrary.
) (
  input  wire logic                                          clk_sys,
  input  wire logic                                          srst,
  input  wire logic [11:0]                                   regAddr,
  input  wire logic                                          regWr,
  input  wire logic                                          regRd,
  input  wire logic [7:0]                                    regWdata,
  output logic      [7:0]                                    regRdata,
  output logic                                               regRdValid,
  input  wire logic                                          cbSocket,
  input  wire logic [2*NUM_SOCKETS-1:0]                      supplyRequestField,
  input  wire logic [NUM_SOCKETS-1:0]                        cardKindSelect,
  input  wire socket_id_status_pkg::socket_pins_s [NUM_SOCKETS-1:0] socketPins
);

  localparam int PIN_W = $bits(socket_id_status_pkg::socket_pins_s);

  // Map as software sees it, per socket, with socket B sitting 40h above socket A.
  //   Index 00h is the identification byte: fixed kind code in 7-6, free storage in 5-4, revision in 3-0.
  //   Index 01h is the interface status byte, built live and never stored.
  //   Index 801h is the same status byte for whichever socket cbSocket names.
  // Every other index reads zero and swallows writes, so a stray host access cannot disturb anything.
  // With a single socket the socket B indexes behave like any other unmapped index.
  // Status byte layout, most significant bit first.
  //   Bit 7 is always zero, 6 is socket powered, 5 is card ready, 4 is write protect.
  //   Bit 3 is the second detect seen low and bit 2 the first detect seen low.
  //   Bits 1-0 are the battery detect pair for a memory card, speaker and status change for an I/O card.
  // The pin bits lag the socket by the synchroniser depth, so software polling right after an insertion
  // may still see the old level for two clocks; that delay buys a read that is never metastable.
  // The power bit is not stored here: it is a decode of the supply request field, which the power
  // register outside this block clears on reset, and that is what makes bits 7-6 read zero then.

  // The index layout has room for exactly two sockets, 40h apart.
  if (NUM_SOCKETS < 1 || NUM_SOCKETS > 2)
  begin : g_bad_sockets
    $error("NUM_SOCKETS must be 1 or 2.");
  end

  // Eight mirrored lines fill the status byte; a different struct would silently shift every bit.
  if (PIN_W != 8)
  begin : g_bad_pins
    $error("The socket line group must be eight bits wide.");
  end

  // The pin latency that software is told about assumes exactly two synchroniser stages.
  if (`SYNC_STAGES != 2)
  begin : g_bad_sync
    $error("The pin synchroniser must have two stages.");
  end

  // The fixed kind code and the stored bits must tile the identification byte exactly.
  if ((`IDENT_KIND_MSB != 7) || (`IDENT_KIND_LSB != `IDENT_STORE_MSB + 1) || (`IDENT_STORE_LSB != 0))
  begin : g_bad_ident_map
    $error("The identification fields must cover bits 7 to 0 without overlap.");
  end

  // The reset word of the stored bits is the reserved pair followed by the revision.
  if ($bits(`IDENT_RESERVED_BITS_RESET) + $bits(REV_DEFAULT) != `IDENT_STORE_MSB - `IDENT_STORE_LSB + 1)
  begin : g_bad_ident_reset
    $error("The identification reset word must match the stored width.");
  end

  // Index decode, shared by the write and the read path so both agree on the map.
  function automatic socket_id_status_pkg::reg_sel_s decodeIndex(
    input logic [11:0] addr,
    input logic        cbSock
  );
    socket_id_status_pkg::reg_sel_s sel;
    sel = '0;
    if (addr == `CB_STATUS_OFFSET)
    begin
      sel.hit      = 1'b1;       // RULE_05
      sel.sock     = cbSock;
      sel.isStatus = 1'b1;
    end
    else if (addr[11:7] == 5'h00)
    begin
      sel.sock = addr[6];        // RULE_04
      if ((addr[6:0] & ~`IDX_SOCKET_B) == `IDX_IDENT)
      begin
        sel.hit = 1'b1;          // RULE_04
      end
      else if ((addr[6:0] & ~`IDX_SOCKET_B) == `IDX_STATUS)
      begin
        sel.hit      = 1'b1;     // RULE_05
        sel.isStatus = 1'b1;
      end
    end
    if (sel.hit && (NUM_SOCKETS == 1) && sel.sock)
    begin
      sel.hit = 1'b0;
    end
    return sel;
  endfunction

  socket_id_status_pkg::reg_sel_s wrSel;
  socket_id_status_pkg::reg_sel_s rdSel;
  logic [7:0] identRead  [2];
  logic [7:0] statusRead [2];

  assign wrSel = decodeIndex(regAddr, cbSocket);
  assign rdSel = wrSel;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sock
      if (gi < NUM_SOCKETS)
      begin : g_live
        logic [5:0]                          identStore_r;
        logic [PIN_W-1:0]                    pinsSynced;
        socket_id_status_pkg::socket_pins_s  pins;
        logic                                powered;

        pin_sync #(
          .WIDTH (PIN_W)
        ) u_sync (
          .clk_sys (clk_sys),
          .pinIn   (socketPins[gi]),
          .pinOut  (pinsSynced)
        );
        assign pins = pinsSynced;

        // Bits 5-0 are stored; the kind code above them has no storage at all.
        always_ff @(posedge clk_sys)
        begin
          if (srst)
          begin
            identStore_r <= {`IDENT_RESERVED_BITS_RESET, REV_DEFAULT}; // RULE_03
          end
          else if (regWr && wrSel.hit && !wrSel.isStatus && (wrSel.sock == 1'(gi)))
          begin
            identStore_r <= regWdata[`IDENT_STORE_MSB:`IDENT_STORE_LSB]; // RULE_02 RULE_03
          end
        end

        // The kind code is wired in at read time, so no write can ever reach it.
        always_comb
        begin
          identRead[gi]                                    = 8'h00;
          identRead[gi][`IDENT_KIND_MSB:`IDENT_KIND_LSB]   = IFACE_KIND;   // RULE_01
          identRead[gi][`IDENT_STORE_MSB:`IDENT_STORE_LSB] = identStore_r; // RULE_02 RULE_03
        end

        // Power is a decode of the supply request, which the power register clears on reset.
        assign powered = supplyRequestField[2*gi+1]; // RULE_15 RULE_07 RULE_14

        // Status is built live from synced pins; nothing in it can be written.
        always_comb
        begin
          statusRead[gi]                  = 8'h00;
          statusRead[gi][`STAT_RESERVED_BITS_BIT]  = 1'b0;              // RULE_06
          statusRead[gi][`STAT_POWER_BIT] = powered;           // RULE_07
          statusRead[gi][`STAT_READY_BIT] = pins.ready;        // RULE_08
          statusRead[gi][`STAT_WP_BIT]    = pins.writeProtect; // RULE_09
          statusRead[gi][`STAT_DETB_BIT]  = ~pins.detectBPin;  // RULE_10
          statusRead[gi][`STAT_DETA_BIT]  = ~pins.detectAPin;  // RULE_11
          if (cardKindSelect[gi])                               // RULE_16
          begin
            statusRead[gi][`STAT_BATB_BIT] = pins.speakerOut;      // RULE_13
            statusRead[gi][`STAT_BATA_BIT] = pins.statusChangeOut; // RULE_13
          end
          else
          begin
            statusRead[gi][`STAT_BATB_BIT] = pins.batteryDetectB;  // RULE_12
            statusRead[gi][`STAT_BATA_BIT] = pins.batteryDetectA;  // RULE_12
          end
        end
      end
      else
      begin : g_absent
        assign identRead[gi]  = 8'h00;
        assign statusRead[gi] = 8'h00;
      end
    end
  endgenerate

  // Read data is registered one cycle after the strobe; unmapped indexes read zero.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      regRdata <= 8'h00;
    end
    else if (regRd)
    begin
      if (!rdSel.hit)
      begin
        regRdata <= 8'h00;
      end
      else if (rdSel.isStatus)
      begin
        regRdata <= statusRead[rdSel.sock]; // RULE_05 RULE_06
      end
      else
      begin
        regRdata <= identRead[rdSel.sock];  // RULE_04
      end
    end
  end

  // One-cycle marker that regRdata holds a fresh answer.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRd;
    end
  end

endmodule // socket_id_and_status_regs

// ==== verilog/socket_id_status_consts.svh ====
// Offsets, field positions, reset values and timing counts of the socket identification and status registers.
// Function
// RULE_01: Bits 7-6 of the identification register return a fixed interface-kind code and ignore writes.
// RULE_02: Bits 5-4 of the identification register are plain read/write storage that returns the last value written.
// RULE_03: Bits 3-0 of the identification register are a read/write compatibility revision that reloads its default on reset.
// RULE_04: The identification register sits at index 00h for socket A and 40h for socket B.
// RULE_05: The interface status register decodes at index 01h for socket A, 41h for socket B and at 801h of the socket space.
// RULE_06: The interface status register is read-only, bit 7 reads zero and writes change nothing.
// RULE_07: Status bit 6 reads 1 while socket power is programmed on and 0 while it is off, as after reset.
// RULE_08: Status bit 5 shows the live level of the card ready line.
// RULE_09: Status bit 4 shows the write-protect input, 1 for a read-only card.
// RULE_10: Status bit 3 shows the inverse of the second card-detect input.
// RULE_11: Status bit 2 shows the inverse of the first card-detect input.
// RULE_12: For a memory card, status bit 1 shows the second battery-detect line and bit 0 the first.
// RULE_13: For an I/O card, status bit 1 shows the speaker output and bit 0 the status-change output.
// RULE_14: After reset, status bits 7-6 read zero while the other bits follow the socket pins.
// RULE_15: The socket counts as powered when the supply request field is 10 or 11, unpowered for 00 and 01.
// RULE_16: The card-kind select bit, 0 memory and 1 I/O, chooses how status bits 1-0 are read.
// RULE_17: Socket inputs are passed through a two-stage synchroniser before they reach the status register.
`ifndef SOCKET_ID_STATUS_CONSTS_SVH
`define SOCKET_ID_STATUS_CONSTS_SVH

`define IDX_IDENT        7'h00
`define IDX_STATUS       7'h01
`define IDX_SOCKET_B     7'h40
`define CB_STATUS_OFFSET 12'h801

`define IDENT_KIND_MSB   7
`define IDENT_KIND_LSB   6
`define IDENT_STORE_MSB  5
`define IDENT_STORE_LSB  0
`define IDENT_RESERVED_BITS_RESET 2'h0

`define STAT_RESERVED_BITS_BIT    7
`define STAT_POWER_BIT   6
`define STAT_READY_BIT   5
`define STAT_WP_BIT      4
`define STAT_DETB_BIT    3
`define STAT_DETA_BIT    2
`define STAT_BATB_BIT    1
`define STAT_BATA_BIT    0

`define SYNC_STAGES      2

`endif

// ==== verilog/socket_id_status_pkg.sv ====
// Types shared by the socket identification and status register logic.
package socket_id_status_pkg;

  // Raw socket lines of one slot; the two detect lines are active low at the pin.
  typedef struct packed {
    logic ready;
    logic writeProtect;
    logic detectBPin;
    logic detectAPin;
    logic batteryDetectB;
    logic batteryDetectA;
    logic speakerOut;
    logic statusChangeOut;
  } socket_pins_s;

  // Result of decoding one register index.
  typedef struct packed {
    logic hit;
    logic sock;
    logic isStatus;
  } reg_sel_s;

endpackage

// ==== verilog/pin_sync.sv ====
// Two-stage synchroniser for a group of socket input lines.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // No reset here on purpose: the status bits must follow the pins straight after reset.
  always_ff @(posedge clk_sys)
  begin
    stage1_r <= pinIn;    // RULE_17
    stage2_r <= stage1_r; // RULE_17
  end

  assign pinOut = stage2_r;

endmodule // pin_sync

// ==== tb/socket_regs_monitor.sv ====
// Port checker of the socket identification and status registers.
`timescale 1ns/1ps
module socket_regs_monitor #(
  parameter int         NUM_SOCKETS = 2,
  parameter logic [1:0] IFACE_KIND  = 2'h3
) (
  input wire logic                                                   clk_sys,
  input wire logic                                                   srst,
  input wire logic [11:0]                                            regAddr,
  input wire logic                                                   regWr,
  input wire logic                                                   regRd,
  input wire logic [7:0]                                             regWdata,
  input wire logic [7:0]                                             regRdata,
  input wire logic                                                   regRdValid,
  input wire logic                                                   cbSocket,
  input wire logic [2*NUM_SOCKETS-1:0]                               supplyRequestField,
  input wire logic [NUM_SOCKETS-1:0]                                 cardKindSelect,
  input wire socket_id_status_pkg::socket_pins_s [NUM_SOCKETS-1:0] socketPins
);
  // Pins must rest three cycles so the synchroniser latency is fully covered.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence pinsQuiet; $stable(socketPins)[*3]; endsequence
  sequence readA; regRd && !regWr && regAddr == 12'h001 && $stable(cardKindSelect); endsequence
  sequence identWrite; regWr && regAddr == 12'h000 ##1 !regWr ##1 regRd && !regWr && regAddr == 12'h000; endsequence
  AST_READ_ANSWER: assert property (regRd |=> regRdValid) else $error("read not answered");
  AST_QUIET_HOLD: assert property (!regRd |=> !regRdValid && $stable(regRdata)) else $error("idle read port moved");
  AST_KIND_FIXED: assert property (regRd && (regAddr == 12'h000 || regAddr == 12'h040) |=>
    regRdata[7:6] == IFACE_KIND) else $error("kind bits wrong");
  AST_IDENT_STORE: assert property (identWrite |=> regRdata[5:0] == $past(regWdata[5:0], 3))
    else $error("ident storage lost");
  AST_STATUS_TOP: assert property (readA and $stable(supplyRequestField) |=>
    regRdata[7:6] == {1'b0, $past(supplyRequestField[1])}) else $error("power bit wrong");
  AST_STATUS_PINS: assert property (pinsQuiet ##0 readA |=>
    regRdata[5:2] == $past({socketPins[0].ready, socketPins[0].writeProtect, ~socketPins[0].detectBPin,
    ~socketPins[0].detectAPin})) else $error("pin bits wrong");
  AST_BATTERY: assert property (pinsQuiet ##0 readA ##0 !cardKindSelect[0] |=>
    regRdata[1:0] == $past({socketPins[0].batteryDetectB, socketPins[0].batteryDetectA}))
    else $error("battery bits wrong");
  AST_SPEAKER: assert property (pinsQuiet ##0 readA ##0 cardKindSelect[0] |=>
    regRdata[1:0] == $past({socketPins[0].speakerOut, socketPins[0].statusChangeOut}))
    else $error("speaker bits wrong");
  AST_UNMAPPED: assert property (regRd && regAddr == 12'h002 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // socket_regs_monitor

bind socket_id_and_status_regs socket_regs_monitor #(.NUM_SOCKETS(NUM_SOCKETS), .IFACE_KIND(IFACE_KIND)) u_mon (
  .clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
  .regRdata(regRdata), .regRdValid(regRdValid), .cbSocket(cbSocket), .supplyRequestField(supplyRequestField),
  .cardKindSelect(cardKindSelect), .socketPins(socketPins));

// ==== tb/card_socket_model.sv ====
// Behavioural model of the cards seated in the sockets.
`timescale 1ns/1ps
module card_socket_model #(
  parameter int NUM_SOCKETS = 2
) (
  input  wire logic [NUM_SOCKETS-1:0]                               inserted,
  input  wire socket_id_status_pkg::socket_pins_s [NUM_SOCKETS-1:0] cardLines,
  output socket_id_status_pkg::socket_pins_s [NUM_SOCKETS-1:0]      socketPins
);
  // A seated card grounds both detect pins; an empty slot leaves them pulled up and the rest low.
  always_comb
  begin
    for (int i = 0; i < NUM_SOCKETS; i++)
      socketPins[i] = inserted[i] ? (cardLines[i] & 8'hCF) : 8'h30;
  end
endmodule // card_socket_model

// ==== tb/socket_id_and_status_regs_bench.sv ====
// Self-checking bench of the socket identification and status registers.
`timescale 1ns/1ps
module socket_id_and_status_regs_bench;
  localparam logic [1:0] KIND = 2'h1;  // Value is arbitrary.
  localparam logic [3:0] REV  = 4'h9;  // Value is arbitrary.
  logic clk_sys = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, cbSocket = 1'b0, regRdValid;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [3:0] supplyRequestField = 4'h0;
  logic [1:0] cardKindSelect = 2'h0, inserted = 2'h0;
  socket_id_status_pkg::socket_pins_s [1:0] cardLines = '0, socketPins;
  int nFail = 0, nChecks = 0, cycles = 0;
  socket_id_and_status_regs #(.NUM_SOCKETS(2), .IFACE_KIND(KIND), .REV_DEFAULT(REV)) u_dut (.clk_sys(clk_sys),
    .srst(srst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
    .regRdValid(regRdValid), .cbSocket(cbSocket), .supplyRequestField(supplyRequestField),
    .cardKindSelect(cardKindSelect), .socketPins(socketPins));
  card_socket_model #(.NUM_SOCKETS(2)) u_card (.inserted(inserted), .cardLines(cardLines), .socketPins(socketPins));
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // A read never waits on the design, yet the run is still cut off well past its expected length.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      nFail++;
      results();
    end
  end
  task automatic results();
    if (nFail == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys) #2;
    {regAddr, regWdata, regWr} = {a, d, 1'b1};
    @(posedge clk_sys) #2;
    regWr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys) #2;
    {regAddr, regRd} = {a, 1'b1};
    @(posedge clk_sys) #2;
    regRd = 1'b0;
    chk({7'h00, regRdValid}, 8'h01);
    chk(regRdata, exp);
  endtask
  // Expected status byte of one socket, worked out from the pins the card model presents.
  function automatic logic [7:0] stat(input int s);
    socket_id_status_pkg::socket_pins_s p;
    logic [1:0] sup;
    p = socketPins[s];
    sup = supplyRequestField[2*s +: 2];
    return {1'b0, sup == 2'h2 || sup == 2'h3, p.ready, p.writeProtect, ~p.detectBPin, ~p.detectAPin,
      cardKindSelect[s] ? {p.speakerOut, p.statusChangeOut} : {p.batteryDetectB, p.batteryDetectA}};
  endfunction
  task automatic t_ident();
    rd(12'h000, {KIND, 2'h0, REV});
    rd(12'h040, {KIND, 2'h0, REV});
    wr(12'h000, 8'hFF);
    wr(12'h040, 8'h25);
    wr(12'h002, 8'h00);
    rd(12'h000, {KIND, 6'h3F});
    rd(12'h040, {KIND, 6'h25});
    rd(12'h002, 8'h00);
    wr(12'h000, 8'h5A);
    rd(12'h000, {KIND, 6'h1A});
  endtask
  task automatic t_status();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys) #2;
      supplyRequestField = {2'(i) ^ 2'h3, 2'(i)};
      cardKindSelect = {~i[2], i[2]};
      inserted = {i[2] ^ i[0], i[3]};
      cardLines = i[3] ? (i[1] ? 16'h36C9 : 16'h63A6) : 16'hE916;
      wr(12'h001, 8'hFF);
      rd(12'h001, stat(0));
      rd(12'h041, stat(1));
      cbSocket = 1'b1;
      rd(12'h801, stat(1));
      cbSocket = 1'b0;
      rd(12'h801, stat(0));
    end
  endtask
  task automatic t_reset();
    @(posedge clk_sys) #2;
    srst = 1'b1;
    // The power register resets with the controller, so its supply request falls back to off.
    supplyRequestField = 4'h0;
    repeat (2) @(posedge clk_sys);
    #2;
    srst = 1'b0;
    rd(12'h000, {KIND, 2'h0, REV});
    rd(12'h040, {KIND, 2'h0, REV});
    rd(12'h001, stat(0));
    rd(12'h041, stat(1));
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #2;
    srst = 1'b0;
    t_ident();
    t_status();
    t_reset();
    results();
  end
endmodule // socket_id_and_status_regs_bench
